// ===== src/nvp_regs.sv
// Protection, option and command object registers of a flash controller.
// Assumes a configuration loader pulses cfg_load once at the end of the
// reset sequence and a command engine asks chk_req before each operation.
//
// Design decision made here: the Avalon-MM register port.
`timescale 1ns/10ps
`default_nettype none

module nvp_regs (
  input wire logic ref_clk,
  input wire logic rst_n,
  // Avalon-MM slave, word addressed.
  input wire logic [3:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [3:0] avs_byteenable,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  // Configuration bytes delivered by the reset sequence.
  input wire logic cfg_load,
  input wire logic [7:0] cfg_flash_protect_ctrl_byte,
  input wire logic [7:0] cfg_eeprom_protect_ctrl_byte,
  input wire logic [7:0] cfg_nonvolatile_option_byte,
  // Protection check request from the command engine.
  input wire logic chk_req,
  input wire logic chk_eeprom,
  input wire logic chk_blk_erase,
  input wire logic [15:0] chk_addr,
  output logic chk_done,
  output logic chk_refused,
  // Option bits and the currently indexed command word.
  output logic [7:0] option_bits,
  output logic [15:0] cmd_word
);

  // Flash protection register, with bit 6 held at one; bits 2:0 reset to ones and are cleared by any load or accepted write.
  logic [7:0] flash_protect_ctrl_q;
  logic [7:0] flash_protect_ctrl_d;
  // EEPROM protection control bit and size field.
  logic ee_ctrl_q;
  logic ee_ctrl_d;
  logic [1:0] dps_q;
  logic [1:0] dps_d;
  // Option register.
  logic [7:0] nonvolatile_option_q;
  // Command object index and storage.
  logic [2:0] cmd_index_q;
  logic [15:0] cmd_mem_q [nvp_pkg::CMD_WORDS];
  // Sticky protection violation flag.
  logic viol_q;
  logic viol_d;
  // Bus handshake and read data.
  logic ack_q;
  logic [31:0] rdata_q;
  // Check answer registers.
  logic done_q;
  logic refused_q;

  // A request is present whenever read or write is high.
  wire bus_req = avs_read | avs_write;
  // The write takes effect in the acknowledge cycle only, lane 0 enabled.
  wire wr_en = avs_write & ack_q & avs_byteenable[0];
  wire [7:0] wbyte = avs_writedata[7:0];

  // Address decode.
  wire sel_index = avs_address == nvp_pkg::IDX_CMD_INDEX;
  wire sel_status = avs_address == nvp_pkg::IDX_CMD_STATUS;
  wire sel_flash_protect_ctrl = avs_address == nvp_pkg::IDX_FLASH_PROT;
  wire sel_eeprom_protect_ctrl = avs_address == nvp_pkg::IDX_EEPROM_PROT;
  wire sel_high = avs_address == nvp_pkg::IDX_CMD_HIGH;
  wire sel_low = avs_address == nvp_pkg::IDX_CMD_LOW;
  wire sel_opt = avs_address == nvp_pkg::IDX_OPTION;

  // An index of six or seven points past the array.
  wire index_ok = cmd_index_q < 3'(nvp_pkg::CMD_WORDS);
  wire [15:0] cur_word = index_ok ? cmd_mem_q[cmd_index_q] : 16'h0000;

  // Field views of the flash protection register.
  wire fp_op = flash_protect_ctrl_q[nvp_pkg::FP_OP_BIT];
  wire fp_hdis = flash_protect_ctrl_q[nvp_pkg::FP_HDIS_BIT];
  wire [1:0] fp_hs = flash_protect_ctrl_q[nvp_pkg::FP_HS_HI:nvp_pkg::FP_HS_LO];

  // Register values as software sees them; reserved low flash bits read zero.
  wire [7:0] flash_protect_ctrl_rd = (flash_protect_ctrl_q & nvp_pkg::FP_WR_MASK) | nvp_pkg::FP_ONE_MASK;
  wire [7:0] eeprom_protect_ctrl_rd = {ee_ctrl_q, 5'h00, dps_q};
  wire [7:0] status_rd = 8'(viol_q) << nvp_pkg::ST_VIOL_BIT;

  // Read data multiplexer; unmapped words read as zero.
  wire [7:0] rd_byte =
    sel_index ? {5'h00, cmd_index_q} :
    sel_status ? status_rd :
    sel_flash_protect_ctrl ? flash_protect_ctrl_rd :
    sel_eeprom_protect_ctrl ? eeprom_protect_ctrl_rd :
    sel_high ? cur_word[15:8] :
    sel_low ? cur_word[7:0] :
    sel_opt ? nonvolatile_option_q :
    8'h00;

  // One wait state: waitrequest drops in the cycle after the request rises.
  assign avs_waitrequest = bus_req & ~ack_q;
  assign avs_readdata = rdata_q;

  // Acknowledge toggles high for one cycle per request.
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      ack_q <= 1'b0;
    end else begin
      ack_q <= bus_req & ~ack_q;
    end
  end

  // Read data is captured in the waiting cycle so it stands at the acknowledge.
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      rdata_q <= 32'h0000_0000;
    end else if (avs_read & ~ack_q) begin
      rdata_q <= {24'h00_0000, rd_byte};
    end
  end

  // Size of the high region for a given size code.
  function automatic logic [16:0] high_size(input logic [1:0] hs);
    high_size = 17'(nvp_pkg::HIGH_BASE_SIZE) << hs;
  endfunction

  // True when the protection of flash value nv covers that of value ov.
  // With the operation bit set the top region is protected; clear, it is
  // the only unprotected region. A disabled range means nothing or all.
  function automatic logic fp_grows(input logic [7:0] ov, input logic [7:0] nv);
    logic o_op;
    logic o_dis;
    logic n_op;
    logic n_dis;
    logic [1:0] o_hs;
    logic [1:0] n_hs;
    o_op = ov[nvp_pkg::FP_OP_BIT];
    o_dis = ov[nvp_pkg::FP_HDIS_BIT];
    o_hs = ov[nvp_pkg::FP_HS_HI:nvp_pkg::FP_HS_LO];
    n_op = nv[nvp_pkg::FP_OP_BIT];
    n_dis = nv[nvp_pkg::FP_HDIS_BIT];
    n_hs = nv[nvp_pkg::FP_HS_HI:nvp_pkg::FP_HS_LO];
    if (!n_op && n_dis) begin
      // New value protects everything.
      fp_grows = 1'b1;
    end else if (o_op && o_dis) begin
      // Old value protected nothing.
      fp_grows = 1'b1;
    end else if (o_op != n_op || o_dis != n_dis) begin
      // Any other change of kind gives up some protected area.
      fp_grows = 1'b0;
    end else if (n_op) begin
      // Protected top region may only grow.
      fp_grows = n_hs >= o_hs;
    end else begin
      // Unprotected top region may only shrink.
      fp_grows = n_hs <= o_hs;
    end
  endfunction

  // Candidate flash value: size bits follow the write only while disabled.
  wire [1:0] cand_hs = fp_hdis ? wbyte[nvp_pkg::FP_HS_HI:nvp_pkg::FP_HS_LO] : fp_hs;
  wire [7:0] fp_cand = ((wbyte & nvp_pkg::FP_WR_MASK) | nvp_pkg::FP_ONE_MASK) &
                       ~(8'h18) | {3'h0, cand_hs, 3'h0};
  wire fp_accept = fp_grows(flash_protect_ctrl_q, fp_cand);

  // Next flash protection value; a refused write leaves it unchanged.
  always_comb begin
    flash_protect_ctrl_d = flash_protect_ctrl_q;
    if (cfg_load) begin
      flash_protect_ctrl_d = (cfg_flash_protect_ctrl_byte & nvp_pkg::FP_WR_MASK) | nvp_pkg::FP_ONE_MASK;
    end else if (wr_en && sel_flash_protect_ctrl && fp_accept) begin
      flash_protect_ctrl_d = fp_cand;
    end
  end

  // Next EEPROM protection fields, each only allowed to add protection.
  always_comb begin
    ee_ctrl_d = ee_ctrl_q;
    dps_d = dps_q;
    if (cfg_load) begin
      ee_ctrl_d = cfg_eeprom_protect_ctrl_byte[nvp_pkg::EE_CTRL_BIT];
      dps_d = cfg_eeprom_protect_ctrl_byte[nvp_pkg::EE_DPS_HI:nvp_pkg::EE_DPS_LO];
    end else if (wr_en && sel_eeprom_protect_ctrl) begin
      // Control bit may only fall from one to zero.
      ee_ctrl_d = ee_ctrl_q & wbyte[nvp_pkg::EE_CTRL_BIT];
      // Size field only takes a larger value.
      if (wbyte[nvp_pkg::EE_DPS_HI:nvp_pkg::EE_DPS_LO] > dps_q) begin
        dps_d = wbyte[nvp_pkg::EE_DPS_HI:nvp_pkg::EE_DPS_LO];
      end
    end
  end

  // Protection registers and option byte.
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      flash_protect_ctrl_q <= nvp_pkg::FP_RESET;
      ee_ctrl_q <= nvp_pkg::EE_RESET[nvp_pkg::EE_CTRL_BIT];
      dps_q <= 2'h0;
      nonvolatile_option_q <= nvp_pkg::OPT_RESET;
    end else begin
      flash_protect_ctrl_q <= flash_protect_ctrl_d;
      ee_ctrl_q <= ee_ctrl_d;
      dps_q <= dps_d;
      if (cfg_load) begin
        nonvolatile_option_q <= cfg_nonvolatile_option_byte;
      end
    end
  end

  // Command object index register.
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      cmd_index_q <= 3'h0;
    end else if (wr_en && sel_index) begin
      cmd_index_q <= wbyte[2:0];
    end
  end

  // One storage word per entry, written a byte at a time.
  for (genvar i = 0; i < nvp_pkg::CMD_WORDS; i++) begin : g_cmd
    wire hit = cmd_index_q == 3'(i);
    always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
        cmd_mem_q[i] <= 16'h0000;
      end else if (wr_en && hit && sel_high) begin
        cmd_mem_q[i][15:8] <= wbyte;
      end else if (wr_en && hit && sel_low) begin
        cmd_mem_q[i][7:0] <= wbyte;
      end
    end
  end

  // Flash protection decode for the checked address.
  wire [16:0] hi_start = 17'(nvp_pkg::FLASH_TOP) + 17'h1 - high_size(fp_hs);
  wire in_high = ({1'b0, chk_addr} >= hi_start) & ~fp_hdis;
  // Set: enabled range is protected. Clear: it is the only open area.
  wire flash_hit = fp_op ? in_high : ~in_high;
  // Some flash is protected unless the range is disabled in protect mode.
  wire flash_any = ~(fp_op & fp_hdis);

  // EEPROM protection decode; the size counts only while control is zero.
  wire [16:0] ee_limit = 17'(nvp_pkg::EE_SECTOR_SIZE) * (17'(dps_q) + 17'h1);
  wire ee_hit = ~ee_ctrl_q & ({1'b0, chk_addr} < ee_limit);
  wire ee_any = ~ee_ctrl_q;

  // A request is refused when it touches, or for block erase may touch,
  // a protected area.
  wire prot_hit = chk_eeprom ?
    (chk_blk_erase ? ee_any : ee_hit) :
    (chk_blk_erase ? flash_any : flash_hit);

  // Violation flag: set by a refused request, cleared by writing a one.
  // A refusal in the same cycle as the clear wins.
  always_comb begin
    viol_d = viol_q;
    if (wr_en && sel_status && wbyte[nvp_pkg::ST_VIOL_BIT]) begin
      viol_d = 1'b0;
    end
    if (chk_req && prot_hit) begin
      viol_d = 1'b1;
    end
  end

  // Violation flag and one-cycle check answers.
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      viol_q <= 1'b0;
      done_q <= 1'b0;
      refused_q <= 1'b0;
    end else begin
      viol_q <= viol_d;
      done_q <= chk_req;
      refused_q <= chk_req & prot_hit;
    end
  end

  assign chk_done = done_q;
  assign chk_refused = refused_q;
  assign option_bits = nonvolatile_option_q;
  assign cmd_word = cur_word;

  // All checks below run on the single clock and stop during reset.
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);

  // Option register follows the configuration byte.
  option_load_a: assert property (cfg_load |=> nonvolatile_option_q == $past(cfg_nonvolatile_option_byte))
    else $error("option register not loaded from configuration byte");

  // Flash protection register follows the writable bits of its byte.
  flash_load_a: assert property (
    cfg_load |=> flash_protect_ctrl_q[7:3] == ($past(cfg_flash_protect_ctrl_byte[7:3]) | 5'h08))
    else $error("flash protection not loaded from configuration byte");

  // Bit 6 reads one and bits 2:0 read zero in every flash protection answer.
  bit_six_a: assert property (
    (avs_read && !avs_waitrequest && sel_flash_protect_ctrl) |->
      (avs_readdata[nvp_pkg::FP_ONE_BIT] == 1'b1 && avs_readdata[2:0] == 3'h0))
    else $error("flash protection reserved bits read wrong");

  // EEPROM fields follow their configuration byte.
  eeprom_load_a: assert property (
    cfg_load |=> {ee_ctrl_q, dps_q} == {$past(cfg_eeprom_protect_ctrl_byte[7]), $past(cfg_eeprom_protect_ctrl_byte[1:0])})
    else $error("EEPROM protection not loaded from configuration byte");

  // Once enabled, EEPROM protection stays enabled until the next load.
  ee_ctrl_hold_a: assert property (
    (!cfg_load && !ee_ctrl_q) |=> !ee_ctrl_q)
    else $error("EEPROM protection control bit rose by a write");

  // EEPROM size never falls by a write.
  ee_size_grow_a: assert property (!cfg_load |=> dps_q >= $past(dps_q))
    else $error("EEPROM protection size decreased");

  // High size stays put while the high range is enabled.
  high_size_lock_a: assert property (
    (!cfg_load && !fp_hdis) |=> fp_hs == $past(fp_hs))
    else $error("high range size changed while range enabled");

  // A refused request raises both the answer and the flag next cycle.
  violation_set_a: assert property (
    (chk_req && prot_hit) |=> (chk_refused && viol_q && chk_done))
    else $error("protected request not refused or flag not set");

  // Flash block erase with anything protected is refused.
  block_erase_a: assert property (
    (chk_req && chk_blk_erase && !chk_eeprom && flash_any) |=> chk_refused)
    else $error("flash block erase allowed with protection present");

  // A high command byte read answer carries the byte decoded in the waiting cycle.
  read_answer_a: assert property (
    (avs_read && avs_waitrequest && sel_high) |=>
      (!avs_waitrequest && avs_readdata[7:0] == $past(cur_word[15:8])))
    else $error("high command byte read data wrong or late");

  // A refused flash protection write leaves the register as it was.
  refused_keep_a: assert property (
    (wr_en && sel_flash_protect_ctrl && !fp_accept && !cfg_load) |=> flash_protect_ctrl_q == $past(flash_protect_ctrl_q))
    else $error("refused flash protection write changed the register");

  // EEPROM block erase with the control bit clear is refused.
  ee_erase_a: assert property (
    (chk_req && chk_blk_erase && chk_eeprom && !ee_ctrl_q) |=> chk_refused)
    else $error("EEPROM block erase allowed with protection present");

  // With the control bit set no EEPROM request is refused, whatever the size.
  ee_off_a: assert property (
    (chk_req && chk_eeprom && ee_ctrl_q) |=> !chk_refused)
    else $error("EEPROM request refused while protection disabled");

  // A disabled high range in protect mode protects no flash address.
  high_off_a: assert property (
    (chk_req && !chk_eeprom && !chk_blk_erase && fp_op && fp_hdis) |=> !chk_refused)
    else $error("flash request refused with high range disabled");

  // Every check request is answered exactly one cycle later.
  done_pulse_a: assert property (chk_done == $past(chk_req))
    else $error("check answer missing or extra");

  // The index register takes the low three bits of its write.
  index_write_a: assert property (
    (wr_en && sel_index) |=> cmd_index_q == $past(wbyte[2:0]))
    else $error("command object index not written");

  // A high byte write lands in bits 15:8 of the indexed word.
  cmd_high_a: assert property (
    (wr_en && sel_high && index_ok) |=> cur_word[15:8] == $past(wbyte))
    else $error("command high byte not written");

  // A low byte write lands in bits 7:0 of the indexed word.
  cmd_low_a: assert property (
    (wr_en && sel_low && index_ok) |=> cur_word[7:0] == $past(wbyte))
    else $error("command low byte not written");

endmodule

`default_nettype wire

// ===== include/nvp_pkg.sv
// Constants for the flash and EEPROM protection and option register block.
// Assumes a single 200 MHz clock and an Avalon-MM slave with a word address.
//
// Notes on behaviour
// - Reset load fills flash protection byte.
// - Flash protection writes may only grow protection.
// - Protected flash program/erase refused, violation flag.
// - Flash block erase refused if anything protected.
// - Operation bit picks protect or unprotect meaning.
// - Flash protection bit 6 always reads one.
// - High range disable bit gates top region.
// - High size writable only while range disabled.
// - EEPROM size writes accepted only when larger.
// - EEPROM control bit only goes one to zero.
// - EEPROM size ignored while control bit set.
// - EEPROM control zero protects sized range.
// - Reset load fills EEPROM protection fields.
// - Protected EEPROM program/erase refused, violation flag.
// - EEPROM block erase refused if any protected.
// - Six command words, index selects, byte access.
// - High byte register maps word bits 15:8.
// - Low byte register maps word bits 7:0.
// - Reset load fills all option bits.
package nvp_pkg;

  // Register indices; the byte address on the bus is four times the index.
  localparam logic [3:0] IDX_CMD_INDEX = 4'h1;
  localparam logic [3:0] IDX_CMD_STATUS = 4'h6;
  localparam logic [3:0] IDX_FLASH_PROT = 4'h8;
  localparam logic [3:0] IDX_EEPROM_PROT = 4'h9;
  localparam logic [3:0] IDX_CMD_HIGH = 4'hA;
  localparam logic [3:0] IDX_CMD_LOW = 4'hB;
  localparam logic [3:0] IDX_OPTION = 4'hC;

  // Configuration byte addresses in flash, kept for reference by the loader.
  localparam logic [15:0] CFG_ADDR_FLASH_PROT = 16'hFF7C;
  localparam logic [15:0] CFG_ADDR_EEPROM_PROT = 16'hFF7D;
  localparam logic [15:0] CFG_ADDR_OPTION = 16'hFF7E;

  // Flash protection register field positions.
  localparam int FP_OP_BIT = 7;
  localparam int FP_ONE_BIT = 6;
  localparam int FP_HDIS_BIT = 5;
  localparam int FP_HS_HI = 4;
  localparam int FP_HS_LO = 3;
  // Writable bits and the bit that is forced to one.
  localparam logic [7:0] FP_WR_MASK = 8'hB8;
  localparam logic [7:0] FP_ONE_MASK = 8'h40;

  // EEPROM protection register field positions.
  localparam int EE_CTRL_BIT = 7;
  localparam int EE_DPS_HI = 1;
  localparam int EE_DPS_LO = 0;

  // Status register field position of the violation flag.
  localparam int ST_VIOL_BIT = 5;

  // Reset values before the configuration load arrives.
  localparam logic [7:0] FP_RESET = 8'hFF;
  localparam logic [7:0] EE_RESET = 8'h80;
  localparam logic [7:0] OPT_RESET = 8'h00;

  // Region geometry: top of flash, smallest high region and EEPROM sector.
  localparam logic [15:0] FLASH_TOP = 16'hFFFF;
  localparam logic [15:0] HIGH_BASE_SIZE = 16'h0400;
  localparam logic [15:0] EE_SECTOR_SIZE = 16'h0020;

  // Number of command object words.
  localparam int CMD_WORDS = 6;

endpackage

// ===== tb/tb.sv
// Self-checking bench for the protection, option and command object registers.
// Assumes the package nvp_pkg is compiled first and the design has one clock.
`timescale 1ns/10ps
`default_nettype none

module tb;
  // Clock, reset and every design input, all driven by the bench.
  logic ref_clk = 1'b0;
  logic rst_n = 1'b0;
  logic [3:0] avs_address = 4'h0;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [3:0] avs_byteenable = 4'hF;
  logic [31:0] avs_writedata = 32'h0;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  logic cfg_load = 1'b0;
  logic [7:0] cfg_flash_protect_ctrl_byte = 8'h00;
  logic [7:0] cfg_eeprom_protect_ctrl_byte = 8'h00;
  logic [7:0] cfg_nonvolatile_option_byte = 8'h00;
  logic chk_req = 1'b0;
  logic chk_eeprom = 1'b0;
  logic chk_blk_erase = 1'b0;
  logic [15:0] chk_addr = 16'h0;
  logic chk_done;
  logic chk_refused;
  logic [7:0] option_bits;
  logic [15:0] cmd_word;
  // Mismatch and comparison counters.
  int n_errors = 0;
  int check_count = 0;

  nvp_regs uut (.ref_clk(ref_clk), .rst_n(rst_n), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_byteenable(avs_byteenable),
    .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .cfg_load(cfg_load),
    .cfg_flash_protect_ctrl_byte(cfg_flash_protect_ctrl_byte), .cfg_eeprom_protect_ctrl_byte(cfg_eeprom_protect_ctrl_byte),
    .cfg_nonvolatile_option_byte(cfg_nonvolatile_option_byte), .chk_req(chk_req), .chk_eeprom(chk_eeprom),
    .chk_blk_erase(chk_blk_erase), .chk_addr(chk_addr), .chk_done(chk_done),
    .chk_refused(chk_refused), .option_bits(option_bits), .cmd_word(cmd_word));

  // The clock toggles every 2.5 ns, a period of 5 ns.
  initial begin
    forever #2.5 ref_clk = ~ref_clk;
  end

  // Prints the counts and the verdict, then ends the run.
  task automatic tally_and_finish();
    $display("errors %0d checks %0d", n_errors, check_count);
    if (n_errors == 0 && check_count > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  // Compares one value with case equality so an unknown never matches.
  task automatic compare(input string what, input logic [31:0] exp, input logic [31:0] got);
    check_count++;
    if (got !== exp) begin
      n_errors++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask

  // One Avalon transfer; waitrequest and readdata are taken at the rising edge.
  task automatic bus(input logic wr, input logic [3:0] adr, input logic [7:0] wd,
                     output logic [31:0] rd);
    logic busy;
    int n;
    busy = 1'b1;
    n = 0;
    rd = 32'h0;
    @(posedge ref_clk);
    avs_address <= adr;
    avs_writedata <= {24'h000000, wd};
    avs_write <= wr;
    avs_read <= !wr;
    while (busy) begin
      @(posedge ref_clk);
      // Values read here are those that stood up to this edge.
      busy = avs_waitrequest;
      n++;
      if (n > 50) begin
        n_errors++;
        tally_and_finish();
      end
    end
    // Read data is taken at the completing edge, then the request is released.
    rd = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask

  // Register write and register read-and-compare shorthands.
  task automatic wr(input logic [3:0] adr, input logic [7:0] d);
    logic [31:0] t;
    bus(1'b1, adr, d, t);
  endtask

  task automatic rd_chk(input string what, input logic [3:0] adr, input logic [7:0] exp);
    logic [31:0] d;
    bus(1'b0, adr, 8'h00, d);
    compare(what, {24'h000000, exp}, d);
  endtask

  // Presents one program or erase request and judges the answer one cycle later.
  task automatic prot_chk(input string what, input logic ee, input logic blk,
                          input logic [15:0] a, input logic exp_ref);
    @(posedge ref_clk);
    chk_req <= 1'b1;
    chk_eeprom <= ee;
    chk_blk_erase <= blk;
    chk_addr <= a;
    @(posedge ref_clk);
    chk_req <= 1'b0;
    @(negedge ref_clk);
    compare("chk_done", 32'h1, {31'h0, chk_done});
    compare(what, {31'h0, exp_ref}, {31'h0, chk_refused});
  endtask

  // Loads the configuration bytes and checks where they land.
  task automatic t_load();
    @(posedge ref_clk);
    cfg_flash_protect_ctrl_byte <= 8'hA0;
    cfg_eeprom_protect_ctrl_byte <= 8'h81;
    cfg_nonvolatile_option_byte <= 8'h5A;
    cfg_load <= 1'b1;
    @(posedge ref_clk);
    cfg_load <= 1'b0;
    rd_chk("flash_protect_ctrl", nvp_pkg::IDX_FLASH_PROT, 8'hE0);
    rd_chk("eeprom_protect_ctrl", nvp_pkg::IDX_EEPROM_PROT, 8'h81);
    rd_chk("nonvolatile_option", nvp_pkg::IDX_OPTION, 8'h5A);
    wr(nvp_pkg::IDX_OPTION, 8'hFF);
    rd_chk("option after write", nvp_pkg::IDX_OPTION, 8'h5A);
    compare("option_bits", 32'h5A, {24'h0, option_bits});
    rd_chk("unmapped index", 4'h0, 8'h00);
  endtask

  // Flash protection: grow only, refusals keep old value, checks and violation flag.
  task automatic t_flash();
    avs_byteenable <= 4'h0;
    wr(nvp_pkg::IDX_FLASH_PROT, 8'hD8);
    avs_byteenable <= 4'hF;
    rd_chk("masked write", nvp_pkg::IDX_FLASH_PROT, 8'hE0);
    prot_chk("flash top unprotected", 1'b0, 1'b0, 16'hFFFF, 1'b0);
    wr(nvp_pkg::IDX_FLASH_PROT, 8'hD8);
    rd_chk("flash grow", nvp_pkg::IDX_FLASH_PROT, 8'hD8);
    // High region of 0x400 << 3 bytes ends at the top of flash.
    prot_chk("flash in region", 1'b0, 1'b0, 16'hE000, 1'b1);
    prot_chk("flash below region", 1'b0, 1'b0, 16'hDFFF, 1'b0);
    prot_chk("flash block erase", 1'b0, 1'b1, 16'h0000, 1'b1);
    rd_chk("violation flag", nvp_pkg::IDX_CMD_STATUS, 8'h20);
    wr(nvp_pkg::IDX_CMD_STATUS, 8'h20);
    rd_chk("violation cleared", nvp_pkg::IDX_CMD_STATUS, 8'h00);
    wr(nvp_pkg::IDX_FLASH_PROT, 8'hC8);
    rd_chk("size locked", nvp_pkg::IDX_FLASH_PROT, 8'hD8);
    wr(nvp_pkg::IDX_FLASH_PROT, 8'hE0);
    rd_chk("flash shrink", nvp_pkg::IDX_FLASH_PROT, 8'hD8);
    wr(nvp_pkg::IDX_FLASH_PROT, 8'h58);
    rd_chk("flash op flip", nvp_pkg::IDX_FLASH_PROT, 8'hD8);
  endtask

  // EEPROM protection: control only one to zero, size only upward.
  task automatic t_eeprom();
    prot_chk("eeprom control off", 1'b1, 1'b0, 16'h0000, 1'b0);
    prot_chk("eeprom erase off", 1'b1, 1'b1, 16'h0000, 1'b0);
    wr(nvp_pkg::IDX_EEPROM_PROT, 8'h00);
    rd_chk("eeprom enable", nvp_pkg::IDX_EEPROM_PROT, 8'h01);
    wr(nvp_pkg::IDX_EEPROM_PROT, 8'h82);
    rd_chk("eeprom grow", nvp_pkg::IDX_EEPROM_PROT, 8'h02);
    // Size 2 protects offsets below 0x20 * 3.
    prot_chk("eeprom in range", 1'b1, 1'b0, 16'h005F, 1'b1);
    prot_chk("eeprom past range", 1'b1, 1'b0, 16'h0060, 1'b0);
    prot_chk("eeprom block erase", 1'b1, 1'b1, 16'h0000, 1'b1);
    rd_chk("eeprom violation", nvp_pkg::IDX_CMD_STATUS, 8'h20);
  endtask

  // Reload as after software reprogrammed the configuration bytes, then widen.
  task automatic t_reload();
    @(posedge ref_clk);
    cfg_flash_protect_ctrl_byte <= 8'h10;
    cfg_eeprom_protect_ctrl_byte <= 8'h00;
    cfg_load <= 1'b1;
    @(posedge ref_clk);
    cfg_load <= 1'b0;
    rd_chk("reloaded flash", nvp_pkg::IDX_FLASH_PROT, 8'h50);
    rd_chk("reloaded eeprom", nvp_pkg::IDX_EEPROM_PROT, 8'h00);
    // Clear operation bit: the top 0x1000 bytes are the only open area.
    prot_chk("flash open top", 1'b0, 1'b0, 16'hF000, 1'b0);
    prot_chk("flash below open", 1'b0, 1'b0, 16'hEFFF, 1'b1);
    prot_chk("eeprom size zero", 1'b1, 1'b0, 16'h0020, 1'b0);
    prot_chk("eeprom size zero in", 1'b1, 1'b0, 16'h001F, 1'b1);
    wr(nvp_pkg::IDX_FLASH_PROT, 8'h60);
    rd_chk("flash all protected", nvp_pkg::IDX_FLASH_PROT, 8'h70);
    prot_chk("flash all top", 1'b0, 1'b0, 16'hFFFF, 1'b1);
  endtask

  // Command object words: six entries, high and low byte windows.
  task automatic t_cmd();
    for (int i = 0; i < 6; i++) begin
      wr(nvp_pkg::IDX_CMD_INDEX, 8'(i));
      wr(nvp_pkg::IDX_CMD_HIGH, 8'hA0 + 8'(i));
      wr(nvp_pkg::IDX_CMD_LOW, 8'h50 + 8'(i));
    end
    for (int i = 0; i < 6; i++) begin
      wr(nvp_pkg::IDX_CMD_INDEX, 8'(i));
      rd_chk("command high", nvp_pkg::IDX_CMD_HIGH, 8'hA0 + 8'(i));
      rd_chk("command low", nvp_pkg::IDX_CMD_LOW, 8'h50 + 8'(i));
      compare("cmd_word", {16'h0, 8'hA0 + 8'(i), 8'h50 + 8'(i)}, {16'h0, cmd_word});
    end
    wr(nvp_pkg::IDX_CMD_INDEX, 8'h06);
    rd_chk("index past array", nvp_pkg::IDX_CMD_HIGH, 8'h00);
  endtask

  // Main sequence: reset for five cycles, then every scenario in turn.
  initial begin
    repeat (5) @(posedge ref_clk);
    rst_n <= 1'b1;
    rd_chk("flash bit six", nvp_pkg::IDX_FLASH_PROT, 8'hF8);
    t_load();
    t_flash();
    t_eeprom();
    t_reload();
    t_cmd();
    tally_and_finish();
  end
endmodule

`default_nettype wire
